//--- design/sbc_mode_pkg.sv
// Package for the operating-mode controller: mode codes, states, timing counts.
// Assumes a 50 MHz single clock and a plain-port host side.
package sbc_mode_pkg;

    // Mode field codes written by the microcontroller
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_STOP = 2'h1;
    localparam logic [1:0] MODE_SLEEP = 2'h2;
    localparam logic [1:0] MODE_SOFT_RESET = 2'h3;
    localparam int MODE_WIDTH = 2;
    localparam int FRAME_BITS = 16;

    // Reset values
    localparam logic [1:0] MODE_RESET = MODE_NORMAL;
    localparam logic CFG_RESET = 1'b0;

    // Timing, in microseconds, and derived cycle counts at 50 MHz
    localparam int CLK_MHZ = 50;
    localparam int RESET_DELAY_US = 10;
    localparam int LONG_WINDOW_US = 200000;
    localparam int RESET_DELAY_CYCLES = RESET_DELAY_US * CLK_MHZ;
    localparam int LONG_WINDOW_CYCLES = LONG_WINDOW_US * CLK_MHZ;

    // Operating states
    typedef enum logic [2:0] {
        ST_INIT,
        ST_NORMAL,
        ST_STOP,
        ST_SLEEP,
        ST_RESTART,
        ST_FAILSAFE
    } sbc_state_t;

    // Microcontroller command carrier
    typedef struct packed {
        logic frameValid;
        logic [FRAME_BITS-1:0] frame;
        logic modeWrite;
        logic [MODE_WIDTH-1:0] mode;
    } spi_cmd_t;

    // Fault and wake inputs
    typedef struct packed {
        logic wake;
        logic wdFail;
        logic mainUnderVolt;
        logic mainOverVolt;
        logic overTemp;
    } sbc_event_t;

    // Latched start-up configuration
    typedef struct packed {
        logic restartOnFail;
        logic devMode;
    } sbc_cfg_t;

endpackage

//--- design/sbc_operating_mode_fsm.sv
// Operating-mode controller of a CAN system basis chip.
// Assumes synchronous inputs on mclk; SPI framing and regulators sit outside.
`timescale 1ns/1ps

module sbc_operating_mode_fsm
    import sbc_mode_pkg::*;
#(
    parameter int RESET_DELAY = RESET_DELAY_CYCLES,
    parameter int LONG_WINDOW = LONG_WINDOW_CYCLES
) (
    input wire logic mclk, // System clock
    input wire logic arst_n, // Power-on reset, active low
    input wire spi_cmd_t cmd, // Whole 16-bit SPI frame and mode write
    input wire sbc_event_t evt, // Wake and fault events
    input wire logic wdTrigger, // Watchdog trigger from SPI
    input wire logic interruptPinLevel, // Sensed level on interrupt pin
    input wire logic testPinLevel, // Sensed level on test pin
    input wire logic lockActive, // Lock bit protects configuration
    output logic reset_output_n, // Reset to microcontroller
    output logic mainRegEnable, // Main regulator enable
    output logic auxSupplyOn, // Auxiliary supply forced on
    output logic canForceNormal, // CAN forced to normal mode
    output logic lowPower, // Reduced power state
    output logic wdRunning, // Watchdog counter running
    output logic wdFailFlag, // Long window expired
    output logic [MODE_WIDTH-1:0] modeBits, // Mode field read back
    output sbc_state_t state, // Current operating state
    output sbc_cfg_t cfg // Latched start-up configuration
);

    // Counter wide enough for the longer of the two timings
    localparam int CW = $clog2(LONG_WINDOW + 1);

    // Refuse counts that the shared counter width cannot serve
    if (RESET_DELAY < 1 || LONG_WINDOW < 1 || LONG_WINDOW < RESET_DELAY) begin : g_bad_timing
        $error("Timing counts out of range");
    end

    sbc_state_t next_state;
    logic [CW-1:0] delayCount, next_delayCount;
    logic [CW-1:0] windowCount, next_windowCount;
    logic windowOpen, next_windowOpen;
    logic [MODE_WIDTH-1:0] next_modeBits;
    sbc_cfg_t next_cfg;
    logic next_wdFailFlag;
    // Set while Fail-Safe was caused or joined by overtemperature
    logic heatEntry, next_heatEntry;
    logic failure;
    logic critical;

    // Sizes a constant to the counter width on purpose
    function automatic logic [CW-1:0] toCount(input int value);
        toCount = CW'(value);
    endfunction

    // Failure sources; configuration picks Restart or Fail-Safe
    assign failure = evt.wdFail | evt.mainUnderVolt | evt.mainOverVolt
        | (windowOpen && windowCount == toCount(LONG_WINDOW - 1) && !wdTrigger);
    assign critical = evt.overTemp | (failure & ~cfg.restartOnFail);

    // Mode state machine and counters
    always_comb begin
        next_state = state;
        next_delayCount = delayCount;
        next_windowCount = windowCount;
        next_windowOpen = windowOpen;
        next_modeBits = modeBits;
        next_cfg = cfg;
        next_wdFailFlag = wdFailFlag;
        next_heatEntry = heatEntry;
        // Long open window: any trigger ends it, development mode stops it at once
        if (windowOpen) begin
            if (wdTrigger || cfg.devMode) begin
                next_windowOpen = 1'b0;
            end else begin
                next_windowCount = windowCount + toCount(1);
            end
            if (windowCount == toCount(LONG_WINDOW - 1) && !wdTrigger && !cfg.devMode) begin
                next_wdFailFlag = 1'b1;
                next_windowOpen = 1'b0;
            end
        end
        // Inside each state, after the Init delay: critical first, then failure, then wake, then command
        case (state)
            ST_INIT: begin
                // Reset held for the delay; pins sampled until release
                if (delayCount != toCount(RESET_DELAY)) begin
                    next_delayCount = delayCount + toCount(1);
                    // A set lock keeps the reset values; the pin levels are not stored
                    if (!lockActive) begin
                        next_cfg.restartOnFail = interruptPinLevel;
                        next_cfg.devMode = testPinLevel;
                    end
                    if (delayCount == toCount(RESET_DELAY - 1)) begin
                        next_windowOpen = 1'b1;
                        next_windowCount = '0;
                    end
                end else if (critical) begin
                    next_state = ST_FAILSAFE;
                end else if (failure && !cfg.devMode) begin
                    next_state = ST_RESTART;
                    next_delayCount = '0;
                end else if (cmd.frameValid) begin
                    next_state = ST_NORMAL;
                end
                // Wake is not looked at here
            end
            ST_NORMAL, ST_STOP, ST_SLEEP: begin
                // Stop has no wake exit; only a command, a failure or overtemperature leaves it
                if (critical) begin
                    next_state = ST_FAILSAFE;
                end else if (failure || (state == ST_SLEEP && evt.wake)) begin
                    next_state = ST_RESTART;
                    next_delayCount = '0;
                end else if (cmd.frameValid && cmd.modeWrite) begin
                    next_modeBits = cmd.mode;
                    case (cmd.mode)
                        MODE_STOP: next_state = ST_STOP;
                        MODE_SLEEP: next_state = ST_SLEEP;
                        MODE_SOFT_RESET: begin
                            next_state = ST_INIT;
                            next_modeBits = MODE_RESET;
                            // Reset line stays high: delay counter parked at its end
                            next_delayCount = toCount(RESET_DELAY);
                            next_windowOpen = 1'b1;
                            next_windowCount = '0;
                        end
                        default: next_state = ST_NORMAL;
                    endcase
                end
            end
            ST_RESTART: begin
                next_modeBits = MODE_RESET;
                // Host is held in reset, so the window must not run out here;
                // a failure that persists restarts the delay
                next_windowOpen = 1'b0;
                if (critical) begin
                    next_state = ST_FAILSAFE;
                end else if (failure) begin
                    next_delayCount = '0;
                end else if (delayCount == toCount(RESET_DELAY - 1)) begin
                    next_state = ST_NORMAL;
                    next_windowOpen = 1'b1;
                    next_windowCount = '0;
                end else begin
                    next_delayCount = delayCount + toCount(1);
                end
            end
            ST_FAILSAFE: begin
                next_windowOpen = 1'b0;
                // Permanent unless woken; a stay caused or joined by heat ends when it cools
                if (evt.wake || (heatEntry && !evt.overTemp)) begin
                    next_state = ST_RESTART;
                    next_delayCount = '0;
                end
            end
            default: next_state = ST_INIT;
        endcase
        // Leaving Fail-Safe forgets the cause; heat seen while inside is kept
        if (next_state != ST_FAILSAFE) begin
            next_heatEntry = 1'b0;
        end else if (evt.overTemp) begin
            next_heatEntry = 1'b1;
        end
    end

    // State registers
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_INIT;
            delayCount <= '0;
            windowCount <= '0;
            windowOpen <= 1'b0;
            modeBits <= MODE_RESET;
            cfg <= '{restartOnFail: CFG_RESET, devMode: CFG_RESET};
            wdFailFlag <= 1'b0;
            heatEntry <= 1'b0;
        end else begin
            state <= next_state;
            delayCount <= next_delayCount;
            windowCount <= next_windowCount;
            windowOpen <= next_windowOpen;
            modeBits <= next_modeBits;
            cfg <= next_cfg;
            wdFailFlag <= next_wdFailFlag;
            heatEntry <= next_heatEntry;
        end
    end

    // Output decode from state, delay count, window flag and configuration
    // Soft reset leaves the reset line high: the host is already running.
    // Fail-Safe keeps reset released; with the regulator off the host is unpowered.
    assign reset_output_n = !(state == ST_RESTART
        || (state == ST_INIT && delayCount != toCount(RESET_DELAY)));
    assign mainRegEnable = !(state == ST_SLEEP || state == ST_FAILSAFE);
    assign lowPower = (state == ST_STOP || state == ST_SLEEP);
    assign auxSupplyOn = cfg.devMode;
    assign canForceNormal = cfg.devMode;
    assign wdRunning = windowOpen && !cfg.devMode;

endmodule

//--- testbench/sbc_mcu_model.sv
// Microcontroller model: sends whole SPI frames and kicks the watchdog.
// Assumes the device takes a frame on the edge where frameValid is high.
`timescale 1ns/1ps
module sbc_mcu_model
    import sbc_mode_pkg::*;
(
    input wire logic mclk, // Clock
    input wire logic reset_output_n, // Reset from device
    input wire logic kickOn, // Keep triggering
    output spi_cmd_t cmd, // Frame to device
    output logic wdTrigger // Trigger pulse
);
    logic [3:0] tick;
    initial begin
        cmd = '0;
        wdTrigger = 1'b0;
        tick = 4'h0;
    end
    // Trigger every 16 cycles, well inside the shortened window
    always @(posedge mclk) begin
        tick <= tick + 4'h1;
        wdTrigger <= kickOn && reset_output_n && tick == 4'hF;
    end
    // Released fields show inverted data so stale values never match
    task automatic send(input logic wr, input logic [1:0] m, input logic [15:0] d);
        @(posedge mclk);
        cmd <= '{frameValid: 1'b1, frame: d, modeWrite: wr, mode: m};
        @(posedge mclk);
        cmd <= '{frameValid: 1'b0, frame: ~d, modeWrite: 1'b0, mode: ~m};
    endtask
endmodule

//--- testbench/sbc_operating_mode_fsm_checker.sv
// Checker of mode outputs against their causes at the ports.
// Assumes single clock mclk and asynchronous active-low arst_n.
`timescale 1ns/1ps
module sbc_operating_mode_fsm_checker
    import sbc_mode_pkg::*;
#(
    parameter int RESET_DELAY = RESET_DELAY_CYCLES
) (
    input wire logic mclk, // Clock
    input wire logic arst_n, // Reset
    input wire spi_cmd_t cmd, // Frame
    input wire sbc_event_t evt, // Events
    input wire logic reset_output_n, // Reset out
    input wire logic mainRegEnable, // Regulator
    input wire logic auxSupplyOn, // Aux supply
    input wire logic canForceNormal, // CAN forced
    input wire logic lowPower, // Low power
    input wire logic wdRunning, // Watchdog runs
    input wire logic wdFailFlag, // Window expired
    input wire logic [MODE_WIDTH-1:0] modeBits, // Mode field
    input wire sbc_state_t state, // State
    input wire sbc_cfg_t cfg // Config
);
    localparam int RD_MAX = RESET_DELAY + 2;
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    chk_restart_reset: assert property (state == ST_RESTART |-> !reset_output_n)
        else $error("reset released in restart");
    chk_sleep_reg: assert property (state == ST_SLEEP |-> !mainRegEnable)
        else $error("regulator on in sleep");
    chk_stop_reg: assert property (state == ST_STOP |-> mainRegEnable && lowPower)
        else $error("stop power levels wrong");
    chk_failsafe_reg: assert property (state == ST_FAILSAFE |-> !mainRegEnable)
        else $error("regulator on in fail-safe");
    chk_restart_clear: assert property ((state == ST_RESTART) [*2] |-> modeBits == 2'h0)
        else $error("mode bits kept in restart");
    chk_dev_forces: assert property (cfg.devMode |-> canForceNormal && auxSupplyOn && !wdRunning)
        else $error("development outputs wrong");
    chk_init_frame: assert property (state == ST_INIT && reset_output_n
        && cmd.frameValid && evt == '0 && !wdFailFlag |=> state == ST_NORMAL)
        else $error("frame left init stuck");
    chk_init_wake: assert property (state == ST_INIT && reset_output_n
        && !cmd.frameValid && evt == sbc_event_t'{wake: 1'b1, default: 1'b0}
        |=> state == ST_INIT || wdFailFlag)
        else $error("wake acted in init");
    chk_restart_time: assert property ($rose(state == ST_RESTART)
        |-> ##[1:RD_MAX] (state != ST_RESTART || evt != '0))
        else $error("restart too long");
    chk_failsafe_hold: assert property (state == ST_FAILSAFE && evt.overTemp
        && !evt.wake |=> state == ST_FAILSAFE)
        else $error("fail-safe left while hot");
endmodule
bind sbc_operating_mode_fsm sbc_operating_mode_fsm_checker #(.RESET_DELAY(RESET_DELAY)) i_chk (
    .mclk(mclk), .arst_n(arst_n), .cmd(cmd), .evt(evt), .reset_output_n(reset_output_n),
    .mainRegEnable(mainRegEnable), .auxSupplyOn(auxSupplyOn), .canForceNormal(canForceNormal),
    .lowPower(lowPower), .wdRunning(wdRunning), .wdFailFlag(wdFailFlag), .modeBits(modeBits),
    .state(state), .cfg(cfg));

//--- testbench/tb_sbc_operating_mode_fsm.sv
// Testbench of the mode controller: drives modes, events and start-up pins.
// Assumes shortened delay and window counts; checks run from a note queue.
`timescale 1ns/1ps
module tb_sbc_operating_mode_fsm;
    import sbc_mode_pkg::*;
    localparam int RD = 8;
    logic mclk, arst_n, wdTrigger, kickOn, testPin, intPin, probe, flag, lockOn;
    logic reset_output_n, mainRegEnable, auxSupplyOn, canForceNormal, lowPower, wdRunning;
    logic wdFailFlag;
    logic [1:0] modeBits, cfgE;
    logic [9:0] notes[$];
    logic [9:0] obs;
    spi_cmd_t cmd;
    sbc_event_t evt;
    sbc_state_t state;
    sbc_cfg_t cfg;
    int fails = 0;
    int totalChecks = 0;
    sbc_mcu_model i_mcu (.mclk(mclk), .reset_output_n(reset_output_n), .kickOn(kickOn),
        .cmd(cmd), .wdTrigger(wdTrigger));
    sbc_operating_mode_fsm #(.RESET_DELAY(RD), .LONG_WINDOW(40)) i_dut (.mclk(mclk),
        .arst_n(arst_n), .cmd(cmd), .evt(evt), .wdTrigger(wdTrigger),
        .interruptPinLevel(intPin), .testPinLevel(testPin), .lockActive(lockOn),
        .reset_output_n(reset_output_n), .mainRegEnable(mainRegEnable), .auxSupplyOn(auxSupplyOn),
        .canForceNormal(canForceNormal), .lowPower(lowPower), .wdRunning(wdRunning),
        .wdFailFlag(wdFailFlag), .modeBits(modeBits), .state(state), .cfg(cfg));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic giveVerdict();
        if (fails == 0 && totalChecks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Note an expected result; the monitor compares it mid-cycle
    task automatic note(input sbc_state_t s, input logic [1:0] m, input logic r, input logic n);
        @(posedge mclk);
        probe <= 1'b1;
        notes.push_back({s, m, r, n, flag, cfgE});
        @(posedge mclk);
        probe <= 1'b0;
    endtask
    task automatic bump(input sbc_event_t e);
        @(posedge mclk);
        evt <= e;
        @(posedge mclk);
        evt <= '0;
    endtask
    // Bounded waits: a hang here shows as a later mismatch
    task automatic waitRst();
        for (int i = 0; i < 60 && reset_output_n !== 1'b1; i++) @(posedge mclk);
    endtask
    always @(negedge mclk) begin
        if (probe === 1'b1) begin
            obs = {state, modeBits, mainRegEnable, reset_output_n, wdFailFlag, cfg};
            totalChecks++;
            if (obs !== notes[0]) begin
                fails++;
                $display("CHECK FAILED outputs expected %h seen %h", notes[0], obs);
            end
            void'(notes.pop_front());
        end
    end
    initial begin
        repeat (5000) @(posedge mclk);
        fails++;
        giveVerdict();
    end
    initial begin
        void'($urandom(16));
        arst_n = 1'b0;
        evt = '0;
        testPin = 1'b0;
        intPin = 1'b1;
        lockOn = 1'b0;
        kickOn = 1'b1;
        probe = 1'b0;
        flag = 1'b0;
        cfgE = 2'h2;
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        waitRst();
        note(ST_INIT, MODE_RESET, 1'b1, 1'b1);
        bump('{wake: 1'b1, default: 1'b0});
        note(ST_INIT, MODE_RESET, 1'b1, 1'b1);
        i_mcu.send(1'b0, MODE_STOP, 16'($urandom()));
        note(ST_NORMAL, MODE_NORMAL, 1'b1, 1'b1);
        i_mcu.send(1'b1, MODE_STOP, 16'($urandom()));
        note(ST_STOP, MODE_STOP, 1'b1, 1'b1);
        i_mcu.send(1'b1, MODE_NORMAL, 16'($urandom()));
        note(ST_NORMAL, MODE_NORMAL, 1'b1, 1'b1);
        i_mcu.send(1'b1, MODE_SLEEP, 16'($urandom()));
        note(ST_SLEEP, MODE_SLEEP, 1'b0, 1'b1);
        bump('{wake: 1'b1, default: 1'b0});
        note(ST_RESTART, 2'h0, 1'b1, 1'b0);
        repeat (RD + 4) @(posedge mclk);
        note(ST_NORMAL, MODE_NORMAL, 1'b1, 1'b1);
        i_mcu.send(1'b1, MODE_SOFT_RESET, 16'($urandom()));
        note(ST_INIT, MODE_RESET, 1'b1, 1'b1);
        i_mcu.send(1'b1, MODE_SLEEP, 16'($urandom()));
        note(ST_NORMAL, MODE_NORMAL, 1'b1, 1'b1);
        bump('{mainUnderVolt: 1'b1, default: 1'b0});
        note(ST_RESTART, 2'h0, 1'b1, 1'b0);
        repeat (RD + 4) @(posedge mclk);
        evt <= '{overTemp: 1'b1, default: 1'b0};
        note(ST_FAILSAFE, 2'h0, 1'b0, 1'b1);
        repeat (6) @(posedge mclk);
        note(ST_FAILSAFE, 2'h0, 1'b0, 1'b1);
        // Stop kicking well before the window reopens; a late pulse would close it
        kickOn <= 1'b0;
        evt <= '0;
        note(ST_RESTART, 2'h0, 1'b1, 1'b0);
        repeat (RD + 4) @(posedge mclk);
        for (int i = 0; i < 200 && wdFailFlag !== 1'b1; i++) @(posedge mclk);
        flag = 1'b1;
        note(ST_RESTART, 2'h0, 1'b1, 1'b0);
        kickOn <= 1'b1;
        arst_n <= 1'b0;
        testPin <= 1'b1;
        intPin <= 1'b0;
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        flag = 1'b0;
        cfgE = 2'h1;
        waitRst();
        note(ST_INIT, MODE_RESET, 1'b1, 1'b1);
        i_mcu.send(1'b0, MODE_NORMAL, 16'($urandom()));
        bump('{mainUnderVolt: 1'b1, default: 1'b0});
        note(ST_FAILSAFE, 2'h0, 1'b0, 1'b1);
        bump('{wake: 1'b1, default: 1'b0});
        note(ST_RESTART, 2'h0, 1'b1, 1'b0);
        repeat (RD + 4) @(posedge mclk);
        kickOn <= 1'b0;
        repeat (80) @(posedge mclk);
        note(ST_NORMAL, MODE_NORMAL, 1'b1, 1'b1);
        // Third start-up with the lock set: changed pins must not be stored
        arst_n <= 1'b0;
        lockOn <= 1'b1;
        intPin <= 1'b1;
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        cfgE = 2'h0;
        waitRst();
        note(ST_INIT, MODE_RESET, 1'b1, 1'b1);
        giveVerdict();
    end
endmodule
